// File: rtl/cco_defs.svh
// constants for the coprocessor conditional-operation engine
`ifndef CCO_DEFS_SVH
`define CCO_DEFS_SVH

// register byte offsets
`define CCO_ADDR_CTRL 8'h00
`define CCO_ADDR_OPWORD 8'h04
`define CCO_ADDR_SELWORD 8'h08
`define CCO_ADDR_EXTCFG 8'h0c
`define CCO_ADDR_DISP 8'h10
`define CCO_ADDR_SCAN 8'h14
`define CCO_ADDR_EADDR 8'h18
`define CCO_ADDR_STATUS 8'h1c
`define CCO_ADDR_NEXTPC 8'h20
`define CCO_ADDR_DREG0 8'h40
`define CCO_ADDR_DREG7 8'h5c

// control fields
`define CCO_CTRL_START 0
`define CCO_CTRL_COPROCESSOR_IDENTIFIER_LSB 1
`define CCO_CTRL_LONG 4

// extension config fields
`define CCO_EXT_CP_LSB 0
`define CCO_EXT_EA_LSB 4

// status fields
`define CCO_ST_BUSY 0
`define CCO_ST_DONE 1
`define CCO_ST_COND 2
`define CCO_ST_TAKEN 3
`define CCO_ST_ERR 4
`define CCO_ST_SVC_LSB 8

// reset values
`define CCO_RST_WORD 32'h0000_0000
`define CCO_RST_HALF 16'h0000

// operation word patterns
`define CCO_FLINE 4'hf
`define CCO_SCC_PAT 3'h1
`define CCO_NATIVE_DECREMENT_BRANCH_PAT 6'h09
`define CCO_BCC_W_PAT 3'h2
`define CCO_BCC_L_PAT 3'h3
`define CCO_EA_DREG_MODE 3'h0

// response word: null primitive and its condition bit
`define CCO_NULL_MASK 16'h3f00
`define CCO_NULL_CODE 16'h0c00
`define CCO_COND_BIT 0

// flag byte values and loop terminal value
`define CCO_FLAG_TRUE 8'hff
`define CCO_FLAG_FALSE 8'h00
`define CCO_LOOP_END 16'hffff

`endif

// File: rtl/cco_pkg.sv
// types and shared arithmetic for the coprocessor conditional-operation engine
package cco_pkg;

  typedef enum logic [1:0] {
    CCO_OP_NONE,
    CCO_OP_BCC,
    CCO_OP_SCC,
    CCO_OP_NATIVE_DECREMENT_BRANCH
  } cco_op_t;

  typedef struct packed {
    cco_op_t op;
    logic long_disp;
    logic [5:0] ea;
    logic [2:0] dreg;
  } cco_dec_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [7:0] data;
  } cco_bwr_t;

  function automatic logic [31:0] cco_sext16(input logic [15:0] w);
    cco_sext16 = {{16{w[15]}}, w};
  endfunction

endpackage

// File: rtl/cco_decode.sv
// operation word decoder for coprocessor conditional instructions
`timescale 1ns/100ps
`include "cco_defs.svh"

module cco_decode import cco_pkg::*; (
  // operation word and configured identifier
  input wire logic [15:0] op_word,
  input wire logic [2:0] coprocessor_identifier,
  // decoded result
  output cco_dec_t dec
);

  // ==========================================================
  // decode
  logic fline;
  logic id_hit;

  assign fline = op_word[15:12] == `CCO_FLINE;
  assign id_hit = op_word[11:9] == coprocessor_identifier;

  always_comb begin
    dec = '0;
    dec.ea = op_word[5:0];
    dec.dreg = op_word[2:0];
    if (fline && id_hit) begin
      if (op_word[8:3] == `CCO_NATIVE_DECREMENT_BRANCH_PAT) begin
        dec.op = CCO_OP_NATIVE_DECREMENT_BRANCH;
      end else if (op_word[8:6] == `CCO_SCC_PAT) begin
        dec.op = CCO_OP_SCC;
      end else if (op_word[8:6] == `CCO_BCC_W_PAT) begin
        dec.op = CCO_OP_BCC;
      end else if (op_word[8:6] == `CCO_BCC_L_PAT) begin
        dec.op = CCO_OP_BCC;
        dec.long_disp = 1'b1;
      end
    end
  end

endmodule

// File: rtl/cco_cp_port.sv
// condition handshake with the coprocessor: write selector, poll response
`timescale 1ns/100ps
`include "cco_defs.svh"

module cco_cp_port import cco_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // engine side
  input wire logic start,
  input wire logic [15:0] sel_word,
  output logic done,
  output logic cond,
  output logic [7:0] svc_cnt,
  // coprocessor side
  output logic cp_cond_wr,
  output logic [15:0] cp_cond_wdata,
  input wire logic cp_cond_ack,
  output logic cp_resp_rd,
  input wire logic cp_resp_ack,
  input wire logic [15:0] cp_resp_rdata
);

  // ==========================================================
  // sequencer
  typedef enum logic [1:0] {P_IDLE, P_WR, P_RD} cco_pst_t;
  cco_pst_t pst_r;
  logic is_null;

  assign is_null = (cp_resp_rdata & `CCO_NULL_MASK) == `CCO_NULL_CODE;
  assign cp_cond_wr = pst_r == P_WR;
  assign cp_resp_rd = pst_r == P_RD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pst_r <= P_IDLE;
    end else begin
      unique case (pst_r)
        P_IDLE: if (start) pst_r <= P_WR;
        P_WR: if (cp_cond_ack) pst_r <= P_RD;
        // service primitives are only counted in svc_cnt; keep polling until null
        P_RD: if (cp_resp_ack && is_null) pst_r <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cp_cond_wdata <= `CCO_RST_HALF;
    end else if (start && pst_r == P_IDLE) begin
      cp_cond_wdata <= sel_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done <= 1'b0;
      cond <= 1'b0;
      svc_cnt <= 8'h00;
    end else begin
      done <= pst_r == P_RD && cp_resp_ack && is_null;
      if (start && pst_r == P_IDLE) begin
        svc_cnt <= 8'h00;
      end else if (pst_r == P_RD && cp_resp_ack) begin
        if (is_null) begin
          cond <= cp_resp_rdata[`CCO_COND_BIT];
        end else begin
          svc_cnt <= svc_cnt + 8'h01;
        end
      end
    end
  end

endmodule

// File: rtl/cco_engine.sv
// coprocessor conditional-operation engine with an AHB-Lite register slave
//
// Notes on behaviour
// - branch on false condition falls through to the next instruction.
// - branch on true: target is scan pointer plus displacement.
// - scan pointer addresses the first displacement word when target is formed.
// - branch displacement is a two's-complement word or long word.
// - a word branch displacement is sign-extended before the add.
// - set-flag form: identifier in bits 11..9, 001 in bits 8..6.
// - set-flag low six bits select the destination byte's addressing mode.
// - set-flag and loop forms write the selector word to the condition register.
// - coprocessor extension word count is configured, never assumed fixed.
// - set-flag ends with zero to five address extension words.
// - after the selector write the response register is read.
// - false set-flag result writes the destination byte as all zeros.
// - true set-flag result writes the destination byte as all ones.
// - loop form: identifier in bits 11..9, 001001 in bits 8..3.
// - loop form bits 2..0 pick the counter data register.
// - loop displacement is the final word after extension words.
// - loop displacement word is sign-extended before the add.
// - loop false: decrement counter low word, fall through at minus one.
// - branch form carries 1111 in bits 15..12 and the selector in bits 5..0.
`timescale 1ns/100ps
`include "cco_defs.svh"

module cco_engine import cco_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // coprocessor condition interface
  output logic cp_cond_wr,
  output logic [15:0] cp_cond_wdata,
  input wire logic cp_cond_ack,
  output logic cp_resp_rd,
  input wire logic cp_resp_ack,
  input wire logic [15:0] cp_resp_rdata,
  // byte write toward memory
  output cco_bwr_t mem_wr,
  input wire logic mem_ack
);

  // ==========================================================
  // registers
  logic [2:0] coprocessor_identifier_r;
  logic long_r;
  logic [15:0] opword_r;
  logic [15:0] selword_r;
  logic [3:0] cp_ext_r;
  logic [2:0] ea_ext_r;
  logic [31:0] disp_r;
  logic [31:0] scan_r;
  logic [31:0] eaddr_r;
  logic [31:0] nextpc_r;
  logic busy_r;
  logic done_r;
  logic cond_r;
  logic taken_r;
  logic err_r;
  logic [31:0] dreg_r [8];
  logic [7:0] svc_cnt;

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic acc;
  logic start;
  logic wr_dreg;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = 32'h0000_0000;
    unique case (a)
      `CCO_ADDR_CTRL: rd_mux = {27'h0, long_r, coprocessor_identifier_r, 1'b0};
      `CCO_ADDR_OPWORD: rd_mux = {16'h0000, opword_r};
      `CCO_ADDR_SELWORD: rd_mux = {16'h0000, selword_r};
      `CCO_ADDR_EXTCFG: rd_mux = {25'h0, ea_ext_r, cp_ext_r};
      `CCO_ADDR_DISP: rd_mux = disp_r;
      `CCO_ADDR_SCAN: rd_mux = scan_r;
      `CCO_ADDR_EADDR: rd_mux = eaddr_r;
      `CCO_ADDR_STATUS: rd_mux = {16'h0000, svc_cnt, 3'h0, err_r, taken_r, cond_r, done_r, busy_r};
      `CCO_ADDR_NEXTPC: rd_mux = nextpc_r;
      default: begin
        if (a >= `CCO_ADDR_DREG0 && a <= `CCO_ADDR_DREG7 && a[1:0] == 2'b00) begin
          rd_mux = dreg_r[a[4:2]];
        end
      end
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `CCO_RST_WORD;
    end else if (acc && !hwrite) begin
      hrdata <= rd_mux(haddr[7:0]);
    end
  end

  assign start = wr_pend_r && wr_addr_r == `CCO_ADDR_CTRL && hwdata[`CCO_CTRL_START] && !busy_r;
  assign wr_dreg = wr_pend_r && wr_addr_r >= `CCO_ADDR_DREG0 && wr_addr_r <= `CCO_ADDR_DREG7;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coprocessor_identifier_r <= 3'h0;
      long_r <= 1'b0;
      opword_r <= `CCO_RST_HALF;
      selword_r <= `CCO_RST_HALF;
      cp_ext_r <= 4'h0;
      ea_ext_r <= 3'h0;
      disp_r <= `CCO_RST_WORD;
      scan_r <= `CCO_RST_WORD;
      eaddr_r <= `CCO_RST_WORD;
    end else if (wr_pend_r && !busy_r) begin
      unique case (wr_addr_r)
        `CCO_ADDR_CTRL: begin
          coprocessor_identifier_r <= hwdata[`CCO_CTRL_COPROCESSOR_IDENTIFIER_LSB +: 3];
          long_r <= hwdata[`CCO_CTRL_LONG];
        end
        `CCO_ADDR_OPWORD: opword_r <= hwdata[15:0];
        `CCO_ADDR_SELWORD: selword_r <= hwdata[15:0];
        `CCO_ADDR_EXTCFG: begin
          cp_ext_r <= hwdata[`CCO_EXT_CP_LSB +: 4];
          ea_ext_r <= hwdata[`CCO_EXT_EA_LSB +: 3];
        end
        `CCO_ADDR_DISP: disp_r <= hwdata;
        `CCO_ADDR_SCAN: scan_r <= hwdata;
        `CCO_ADDR_EADDR: eaddr_r <= hwdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // decode and coprocessor handshake
  cco_dec_t dec;
  logic cp_done;
  logic cp_cond;
  logic [15:0] cond_word;
  logic [2:0] coprocessor_identifier_sel;

  // an identifier written together with start must govern that same start
  assign coprocessor_identifier_sel = (wr_pend_r && wr_addr_r == `CCO_ADDR_CTRL && !busy_r)
    ? hwdata[`CCO_CTRL_COPROCESSOR_IDENTIFIER_LSB +: 3] : coprocessor_identifier_r;

  cco_decode u_dec (
    .op_word(opword_r),
    .coprocessor_identifier(coprocessor_identifier_sel),
    .dec(dec)
  );

  // the branch form carries its selector in the operation word itself
  assign cond_word = (dec.op == CCO_OP_BCC) ? opword_r : selword_r;

  cco_cp_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start && dec.op != CCO_OP_NONE),
    .sel_word(cond_word),
    .done(cp_done),
    .cond(cp_cond),
    .svc_cnt(svc_cnt),
    .cp_cond_wr(cp_cond_wr),
    .cp_cond_wdata(cp_cond_wdata),
    .cp_cond_ack(cp_cond_ack),
    .cp_resp_rd(cp_resp_rd),
    .cp_resp_ack(cp_resp_ack),
    .cp_resp_rdata(cp_resp_rdata)
  );

  // ==========================================================
  // address arithmetic
  logic [31:0] disp_ptr;
  logic [31:0] disp_val;
  logic [31:0] target;
  logic [31:0] after_disp;
  logic [31:0] after_ea;
  logic [15:0] cnt_dec;
  logic ea_is_dreg;

  // pointer to the first displacement word, past any extension words
  assign disp_ptr = scan_r + ((dec.op == CCO_OP_BCC) ? 32'h2 : 32'h4)
    + {27'h0, cp_ext_r, 1'b0};
  assign disp_val = (dec.op == CCO_OP_BCC && dec.long_disp) ? disp_r
    : cco_sext16(disp_r[15:0]);
  assign target = disp_ptr + disp_val;
  assign after_disp = disp_ptr + ((dec.long_disp && dec.op == CCO_OP_BCC) ? 32'h4 : 32'h2);
  assign after_ea = disp_ptr + {28'h0, ea_ext_r, 1'b0};
  assign cnt_dec = dreg_r[dec.dreg][15:0] - 16'h0001;
  assign ea_is_dreg = dec.ea[5:3] == `CCO_EA_DREG_MODE;

  // ==========================================================
  // execution sequence
  typedef enum logic [1:0] {S_IDLE, S_COND, S_EXEC, S_BYTE} cco_st_t;
  cco_st_t st_r;
  logic flag_cond;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_IDLE;
    end else begin
      unique case (st_r)
        S_IDLE: if (start && dec.op != CCO_OP_NONE) st_r <= S_COND;
        S_COND: if (cp_done) st_r <= S_EXEC;
        S_EXEC: st_r <= (dec.op == CCO_OP_SCC && !ea_is_dreg) ? S_BYTE : S_IDLE;
        S_BYTE: if (mem_ack) st_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cond_r <= 1'b0;
      taken_r <= 1'b0;
      err_r <= 1'b0;
      nextpc_r <= `CCO_RST_WORD;
    end else begin
      if (start) begin
        busy_r <= dec.op != CCO_OP_NONE;
        done_r <= dec.op == CCO_OP_NONE;
        err_r <= dec.op == CCO_OP_NONE;
        taken_r <= 1'b0;
      end else if (st_r == S_EXEC) begin
        cond_r <= cp_cond;
        unique case (dec.op)
          CCO_OP_BCC: begin
            taken_r <= cp_cond;
            nextpc_r <= cp_cond ? target : after_disp;
          end
          CCO_OP_NATIVE_DECREMENT_BRANCH: begin
            taken_r <= !cp_cond && cnt_dec != `CCO_LOOP_END;
            nextpc_r <= (!cp_cond && cnt_dec != `CCO_LOOP_END) ? target : after_disp;
          end
          default: nextpc_r <= after_ea;
        endcase
        if (!(dec.op == CCO_OP_SCC && !ea_is_dreg)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end else if (st_r == S_BYTE && mem_ack) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

  assign flag_cond = cp_cond;

  // memory destination: a single byte-wide write request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_wr <= '0;
    end else if (st_r == S_EXEC && dec.op == CCO_OP_SCC && !ea_is_dreg) begin
      mem_wr.req <= 1'b1;
      mem_wr.addr <= eaddr_r;
      mem_wr.data <= flag_cond ? `CCO_FLAG_TRUE : `CCO_FLAG_FALSE;
    end else if (mem_ack) begin
      mem_wr.req <= 1'b0;
    end
  end

  // data registers; engine update wins over a colliding bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++) begin
        dreg_r[i] <= `CCO_RST_WORD;
      end
    end else if (st_r == S_EXEC && dec.op == CCO_OP_NATIVE_DECREMENT_BRANCH && !cp_cond) begin
      dreg_r[dec.dreg][15:0] <= cnt_dec;
    end else if (st_r == S_EXEC && dec.op == CCO_OP_SCC && ea_is_dreg) begin
      dreg_r[dec.ea[2:0]][7:0] <= flag_cond ? `CCO_FLAG_TRUE : `CCO_FLAG_FALSE;
    end else if (wr_dreg) begin
      dreg_r[wr_addr_r[4:2]] <= hwdata;
    end
  end

endmodule

// File: test/cco_engine_chk.sv
// port checker for the conditional-operation engine
`timescale 1ns/100ps
`include "cco_defs.svh"
module cco_engine_chk import cco_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // coprocessor link
  input wire logic cp_cond_wr,
  input wire logic [15:0] cp_cond_wdata,
  input wire logic cp_cond_ack,
  input wire logic cp_resp_rd,
  input wire logic cp_resp_ack,
  input wire logic [15:0] cp_resp_rdata,
  // byte write
  input wire cco_bwr_t mem_wr,
  input wire logic mem_ack
);
  logic last_cond_r;
  logic is_null;
  assign is_null = (cp_resp_rdata & `CCO_NULL_MASK) == `CCO_NULL_CODE;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // =====
  // handshake steps
  sequence cond_hs;
    cp_cond_wr && cp_cond_ack;
  endsequence
  sequence resp_hs;
    cp_resp_rd && cp_resp_ack;
  endsequence
  sequence null_ack;
    resp_hs ##0 is_null;
  endsequence
  sequence svc_ack;
    resp_hs ##0 !is_null;
  endsequence
  // =====
  // last final answer, the flag byte must follow it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_cond_r <= 1'b0;
    end else if (cp_resp_rd && cp_resp_ack && is_null) begin
      last_cond_r <= cp_resp_rdata[`CCO_COND_BIT];
    end
  end
  // =====
  // rules
  cond_hold_a: assert property (cp_cond_wr && !cp_cond_ack |=>
    cp_cond_wr && $stable(cp_cond_wdata)) else $error("selector write dropped early");
  cond_poll_a: assert property (cond_hs |=> cp_resp_rd)
    else $error("no response read after selector write");
  poll_cause_a: assert property ($rose(cp_resp_rd) |-> $past(cp_cond_ack))
    else $error("response read without selector write");
  svc_poll_a: assert property (svc_ack |=> cp_resp_rd)
    else $error("polling stopped after service primitive");
  null_stop_a: assert property (null_ack |=> !cp_resp_rd)
    else $error("polling went on after null primitive");
  poll_excl_a: assert property (cp_resp_rd |-> !cp_cond_wr)
    else $error("selector write while polling");
  mem_hold_a: assert property (mem_wr.req && !mem_ack |=>
    mem_wr.req && $stable(mem_wr.addr) && $stable(mem_wr.data)) else $error("byte write unstable");
  flag_val_a: assert property (mem_wr.req |->
    mem_wr.data == (last_cond_r ? `CCO_FLAG_TRUE : `CCO_FLAG_FALSE)) else $error("bad flag byte");
endmodule
bind cco_engine cco_engine_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .cp_cond_wr(cp_cond_wr), .cp_cond_wdata(cp_cond_wdata),
  .cp_cond_ack(cp_cond_ack), .cp_resp_rd(cp_resp_rd), .cp_resp_ack(cp_resp_ack),
  .cp_resp_rdata(cp_resp_rdata), .mem_wr(mem_wr), .mem_ack(mem_ack)
);

// File: test/cco_cp_model.sv
// behavioural coprocessor and byte memory at the engine's far side
`timescale 1ns/100ps
module cco_cp_model import cco_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // condition link
  input wire logic cp_cond_wr,
  input wire logic [15:0] cp_cond_wdata,
  output logic cp_cond_ack,
  input wire logic cp_resp_rd,
  output logic cp_resp_ack,
  output logic [15:0] cp_resp_rdata,
  // byte memory
  input wire cco_bwr_t mem_wr,
  output logic mem_ack,
  // scenario control and capture
  input wire logic cond_val,
  input wire logic [3:0] svc_n,
  input wire logic [3:0] dly,
  output logic [15:0] cap_word,
  output logic [39:0] cap_mem
);
  logic [3:0] cnt_r;
  logic [3:0] svc_r;
  // =====
  // coprocessor answers, slowed by dly cycles; byte writes acked the next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cp_cond_ack, cp_resp_ack, mem_ack, cnt_r, svc_r} <= '0;
      {cp_resp_rdata, cap_word, cap_mem} <= '0;
    end else begin
      cp_cond_ack <= 1'b0;
      cp_resp_ack <= 1'b0;
      mem_ack <= 1'b0;
      // data toggles between acks so a stale read never looks valid
      cp_resp_rdata <= ~cp_resp_rdata;
      if ((cp_cond_wr && !cp_cond_ack) || (cp_resp_rd && !cp_resp_ack)) begin
        cnt_r <= cnt_r + 4'h1;
      end
      if (cp_cond_wr && !cp_cond_ack && cnt_r >= dly) begin
        cp_cond_ack <= 1'b1;
        cap_word <= cp_cond_wdata;
        svc_r <= svc_n;
        cnt_r <= 4'h0;
      end
      if (cp_resp_rd && !cp_resp_ack && cnt_r >= dly) begin
        cp_resp_ack <= 1'b1;
        cnt_r <= 4'h0;
        svc_r <= svc_r - 4'h1;
        if (svc_r != 4'h0) begin
          cp_resp_rdata <= 16'h8100;
        end else begin
          cp_resp_rdata <= 16'h0c00 | {15'h0000, cond_val};
        end
      end
      if (mem_wr.req && !mem_ack) begin
        mem_ack <= 1'b1;
        cap_mem <= {mem_wr.addr, mem_wr.data};
      end
    end
  end
endmodule

// File: test/cco_engine_test.sv
// self-checking bench for the conditional-operation engine
`timescale 1ns/100ps
`include "cco_defs.svh"
module cco_engine_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, cp_cond_wr, cp_cond_ack, cp_resp_rd, cp_resp_ack, mem_ack;
  logic [31:0] hrdata, st, npc, q;
  logic [15:0] cp_cond_wdata, cp_resp_rdata, cap_word;
  logic [39:0] cap_mem;
  cco_pkg::cco_bwr_t mem_wr;
  logic cond_val = 1'b0;
  logic [3:0] svc_n = 4'h0;
  logic [3:0] dly = 4'h0;
  int num_errors = 0;
  int compares = 0;
  wire hready = hreadyout;
  localparam logic [31:0] scan_a = 32'h0000_1000;
  localparam logic [31:0] ea_a = 32'h0000_2003;
  always #2.5 hclk = ~hclk;
  cco_engine uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cp_cond_wr(cp_cond_wr),
    .cp_cond_wdata(cp_cond_wdata), .cp_cond_ack(cp_cond_ack), .cp_resp_rd(cp_resp_rd),
    .cp_resp_ack(cp_resp_ack), .cp_resp_rdata(cp_resp_rdata), .mem_wr(mem_wr),
    .mem_ack(mem_ack));
  cco_cp_model cp (.hclk(hclk), .hresetn(hresetn), .cp_cond_wr(cp_cond_wr),
    .cp_cond_wdata(cp_cond_wdata), .cp_cond_ack(cp_cond_ack), .cp_resp_rd(cp_resp_rd),
    .cp_resp_ack(cp_resp_ack), .cp_resp_rdata(cp_resp_rdata), .mem_wr(mem_wr),
    .mem_ack(mem_ack), .cond_val(cond_val), .svc_n(svc_n), .dly(dly),
    .cap_word(cap_word), .cap_mem(cap_mem));
  // =====
  // reporting
  task automatic end_sim();
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // =====
  // ahb-lite single transfers
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  // =====
  // one instruction: load, start, poll until done and idle
  task automatic run(input logic [15:0] op, input logic [15:0] sel, input logic [7:0] ext,
                     input logic [31:0] disp, input logic c, input logic [3:0] s);
    int n;
    cond_val <= c;
    svc_n <= s;
    wr(`CCO_ADDR_OPWORD, {16'h0, op});
    wr(`CCO_ADDR_SELWORD, {16'h0, sel});
    wr(`CCO_ADDR_EXTCFG, {24'h0, ext});
    wr(`CCO_ADDR_DISP, disp);
    wr(`CCO_ADDR_SCAN, scan_a);
    wr(`CCO_ADDR_EADDR, ea_a);
    wr(`CCO_ADDR_CTRL, 32'h0000_0003);
    // one idle edge so a done left from the last run is not mistaken
    @(posedge hclk);
    n = 0;
    do begin
      rd(`CCO_ADDR_STATUS, st);
      n++;
    end while (!(st[1] === 1'b1 && st[0] === 1'b0) && n < 60);
    if (n >= 60) begin
      num_errors++;
      end_sim();
    end
    rd(`CCO_ADDR_NEXTPC, npc);
  endtask
  task automatic dbt(input logic [31:0] d0, input logic c, input logic [31:0] de,
                     input logic [31:0] pe);
    logic [31:0] v;
    wr(`CCO_ADDR_DREG0 + 8'h08, d0);
    run(16'hf24a, 16'h0007, 8'h01, 32'h0000_fffc, c, 4'h0);
    rd(`CCO_ADDR_DREG0 + 8'h08, v);
    chk("loop_reg", de, v);
    chk("loop_pc", pe, npc);
  endtask
  // =====
  // main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`CCO_ADDR_STATUS, q);
    chk("status_rst", 32'h0, q);
    rd(8'hfc, q);
    chk("unmapped", 32'h0, q);
    run(16'hf285, 16'h0000, 8'h00, 32'h0000_0010, 1'b0, 4'h0);
    chk("bw_false_pc", 32'h0000_1004, npc);
    chk("bw_word", 32'h0000_f285, {16'h0, cap_word});
    run(16'hf285, 16'h0000, 8'h02, 32'h0000_fff0, 1'b1, 4'h2);
    chk("bw_true_pc", 32'h0000_0ff6, npc);
    chk("bw_svc_st", 32'h0000_020e, st & 32'h0000_ff1f);
    run(16'hf2c5, 16'h0000, 8'h01, 32'h0001_0000, 1'b1, 4'h0);
    chk("bl_true_pc", 32'h0001_1004, npc);
    run(16'hf2c5, 16'h0000, 8'h01, 32'h0001_0000, 1'b0, 4'h0);
    chk("bl_false_pc", 32'h0000_1008, npc);
    wr(`CCO_ADDR_DREG0 + 8'h0c, 32'h1234_5600);
    run(16'hf243, 16'h0007, 8'h01, 32'h0, 1'b1, 4'h0);
    rd(`CCO_ADDR_DREG0 + 8'h0c, q);
    chk("scc_reg", 32'h1234_56ff, q);
    chk("scc_sel", 32'h0000_0007, {16'h0, cap_word});
    chk("scc_pc", 32'h0000_1006, npc);
    // slow coprocessor, longest address extension
    dly <= 4'h3;
    for (int i = 0; i < 2; i++) begin
      run(16'hf250, 16'h0007, 8'h50, 32'h0, i[0], 4'h1);
      chk("scc_addr", ea_a, cap_mem[39:8]);
      chk("scc_byte", {24'h0, {8{i[0]}}}, {24'h0, cap_mem[7:0]});
      chk("scc_pc", 32'h0000_100e, npc);
      chk("scc_st", {22'h0, 8'h01, i[0], 1'b1}, {22'h0, st[15:8], st[2:1]});
    end
    dly <= 4'h0;
    dbt(32'habcd_0001, 1'b0, 32'habcd_0000, 32'h0000_1002);
    dbt(32'habcd_0000, 1'b0, 32'habcd_ffff, 32'h0000_1008);
    dbt(32'habcd_0005, 1'b1, 32'habcd_0005, 32'h0000_1008);
    // wrong identifier, then a general-category word: neither may reach the link
    run(16'hf485, 16'h0033, 8'h00, 32'h0, 1'b1, 4'h0);
    // a refused start keeps the last condition and clears taken
    chk("bad_id_st", 32'h0000_0016, st & 32'h0000_ff1f);
    run(16'hf205, 16'h0033, 8'h00, 32'h0, 1'b1, 4'h0);
    chk("bad_pat_st", 32'h0000_0016, st & 32'h0000_ff1f);
    chk("no_traffic", 32'h0000_0007, {16'h0, cap_word});
    rd(`CCO_ADDR_CTRL, q);
    chk("ctrl_rb", 32'h0000_0002, q);
    end_sim();
  end
endmodule
